// [src/dpp_counter.sv]
// Purpose: One 16-bit down counter with load sequence, gate and output
// Assumes: tick is a one-cycle pulse marking a rising edge of its source
// Notes:   Modes with bit 1 set reload and pulse; others run to terminal count
`timescale 1ns/10ps
module dpp_counter
   import dpp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       tick,
   input  wire logic       gate,
   input  wire logic       load_wr,
   input  wire logic       mode_wr,
   input  wire logic [7:0] wdata,
   output logic            cnt_out
);

   logic [2:0]  mode_ff;
   logic [15:0] reload_ff;
   logic [15:0] count_ff;
   dpp_cst_t    state_ff;
   logic        out_ff;

   wire         periodic = mode_ff[CTL_PERIODIC];
   wire         run_tick = (state_ff == DPP_CST_RUN) && tick && gate;
   wire [15:0]  count_dec = count_ff - CNT_ONE;

   assign cnt_out = out_ff;

   // Mode write parks the counter; LSB then MSB arms it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_ff   <= 3'h0;
         reload_ff <= CNT_RST;
         count_ff  <= CNT_RST;
         state_ff  <= DPP_CST_IDLE;
         out_ff    <= 1'b0;
      end else if (mode_wr) begin
         mode_ff  <= wdata[CTL_M_LO +: 3];
         state_ff <= DPP_CST_IDLE;
         out_ff   <= wdata[CTL_M_LO + CTL_PERIODIC];
      end else if (load_wr) begin
         case (state_ff)
            DPP_CST_MSB: begin
               reload_ff[15:8] <= wdata;
               count_ff        <= {wdata, reload_ff[7:0]};
               state_ff        <= DPP_CST_RUN;
               out_ff          <= periodic;
            end
            default: begin
               reload_ff[7:0] <= wdata;
               state_ff       <= DPP_CST_MSB;
            end
         endcase
      end else if (run_tick) begin
         // Zero loads as a full 65536 count through natural wrap
         if (periodic && count_ff == CNT_ONE) begin
            count_ff <= reload_ff;
            out_ff   <= 1'b1;
         end else begin
            count_ff <= count_dec;
            if (periodic) begin
               out_ff <= (count_ff != CNT_TWO);
            end else if (count_ff == CNT_ONE) begin
               out_ff <= 1'b1;
            end
         end
      end
   end

endmodule

// [src/dpp_pkg.sv]
// Purpose: Shared constants and types for the dual parallel port block
// Assumes: 8-bit host register port, byte offsets as printed
// Notes:   Group 0 ports occupy pin bits 23:0, group 1 ports bits 47:24
package dpp_pkg;

   // Register offsets
   localparam logic [5:0] OFF_G0_PA   = 6'h00;
   localparam logic [5:0] OFF_G0_PB   = 6'h01;
   localparam logic [5:0] OFF_G0_PC   = 6'h02;
   localparam logic [5:0] OFF_G0_CTL  = 6'h03;
   localparam logic [5:0] OFF_G1_PA   = 6'h04;
   localparam logic [5:0] OFF_G1_PB   = 6'h05;
   localparam logic [5:0] OFF_G1_PC   = 6'h06;
   localparam logic [5:0] OFF_G1_CTL  = 6'h07;
   localparam logic [5:0] OFF_CNT0    = 6'h18;
   localparam logic [5:0] OFF_CNT1    = 6'h19;
   localparam logic [5:0] OFF_CNT2    = 6'h1A;
   localparam logic [5:0] OFF_CNT_CTL = 6'h1B;
   localparam logic [5:0] OFF_IRQ     = 6'h20;

   // Port and counter geometry
   localparam int PORT_W   = 8;
   localparam int NIB_W    = 4;
   localparam int PINS     = 48;
   localparam int NPORTS   = 6;
   localparam int NSECT    = 8;
   localparam int NCNT     = 3;
   localparam int G0_PC0   = 16;
   localparam int G0_PC4   = 20;
   localparam int G1_PC0   = 40;
   localparam int G1_PC4   = 44;
   localparam logic [2:0] G1_BYTE_BASE = 3'h3;

   // Direction control word fields, 1 = input
   localparam int CW_PCL = 0;
   localparam int CW_PB  = 1;
   localparam int CW_PCH = 3;
   localparam int CW_PA  = 4;

   // Interrupt control/status fields
   localparam int IRQ_M0_LO = 0;
   localparam int IRQ_E0    = 2;
   localparam int IRQ_F0    = 3;
   localparam int IRQ_M1_LO = 4;
   localparam int IRQ_E1    = 6;
   localparam int IRQ_F1    = 7;

   // Counter control word fields
   localparam int CTL_SC_LO = 6;
   localparam int CTL_M_LO  = 1;
   localparam int CTL_PERIODIC = 1;

   // Reset values and counter constants
   localparam logic [7:0]  REG_RST  = 8'h00;
   localparam logic [47:0] OUT_RST  = 48'h0000_0000_0000;
   localparam logic [15:0] CNT_RST  = 16'h0000;
   localparam logic [15:0] CNT_ONE  = 16'h0001;
   localparam logic [15:0] CNT_TWO  = 16'h0002;

   // Interrupt source selection per channel
   typedef enum logic [1:0] {
      DPP_SRC_OFF = 2'b00,
      DPP_SRC_PC0 = 2'b01,
      DPP_SRC_CNT = 2'b10,
      DPP_SRC_PC4 = 2'b11
   } dpp_src_t;

   // Counter load sequence, Gray along idle -> msb wait -> run
   typedef enum logic [1:0] {
      DPP_CST_IDLE = 2'b00,
      DPP_CST_MSB  = 2'b01,
      DPP_CST_RUN  = 2'b11
   } dpp_cst_t;

endpackage

// [src/dpp_top.sv]
// Purpose: Two mode-0 parallel port groups with retention, interrupts, counters
// Assumes: por_b falls only on loss of supply; rst_b is also asserted at power-up
// Notes:   Pins are split into in/out/oe; pull-ups sit outside the block
//
// Contract
// - Two groups of ports A, B, C; port C halves directed independently.
// - Control word at offset 3 sets group 0, offset 7 group 1.
// - Strap-forced output sections ignore direction bits of control words.
// - A port turned output drives its latch value at once.
// - Host can read back the driven value of every output port.
// - Without retention, software ports leave reset as inputs, pulled high.
// - Strap-forced ports leave reset as outputs driving 0 unless restored.
// - Retention strap restores direction and latch values after hot reset.
// - Loss of supply discards retained state; defaults apply next power-up.
// - Port C bit 0 of each group feeds the interrupt logic.
// - Register at offset 32 selects the interrupt sources.
// - Interrupt output pin high while an interrupt pends, low once cleared.
// - Three 16-bit down counters with clock, gate and output.
// - Counter clock strap picks pin or internal; 10 MHz for 0 and 2.
// - Counter 1 internal clock is counter 0 output, cascading to 32 bits.
// - External clock on counter 0 with cascade forms 32-bit event counter.
// - Counter 2 is timer on internal clock, event counter on pin.
// - Counter 1 and counter 2 outputs feed the interrupt logic.
// - Gates are high by default yet drivable from connector gate pins.
// - Edge bit 1 triggers on rising, 0 on falling source edge.
// - Flag reads 1 while pending, clears on writing 1.
`timescale 1ns/10ps
module dpp_top
   import dpp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        por_b,
   input  wire logic [5:0]  bus_addr,
   input  wire logic        bus_wr,
   input  wire logic        bus_rd,
   input  wire logic [7:0]  bus_wdata,
   output logic [7:0]       bus_rdata,
   input  wire logic [47:0] port_in,
   output logic [47:0]      port_out,
   output logic [47:0]      port_oe,
   input  wire logic        state_retention_strap,
   input  wire logic        group0_porta_direction_strap,
   input  wire logic        group0_portb_direction_strap,
   input  wire logic        group0_portc_low_direction_strap,
   input  wire logic        group0_portc_high_direction_strap,
   input  wire logic        group1_porta_direction_strap,
   input  wire logic        group1_portb_direction_strap,
   input  wire logic        group1_portc_low_direction_strap,
   input  wire logic        group1_portc_high_direction_strap,
   input  wire logic        counter0_clock_select_strap,
   input  wire logic        counter1_clock_select_strap,
   input  wire logic        counter2_clock_select_strap,
   input  wire logic        int_clock_10m,
   input  wire logic        counter0_ext_clock_pin,
   input  wire logic        counter1_ext_clock_pin,
   input  wire logic        counter2_ext_clock_pin,
   input  wire logic        counter0_gate_pin,
   input  wire logic        counter1_gate_pin,
   input  wire logic        counter2_gate_pin,
   output logic             counter0_output_pin,
   output logic             counter1_output_pin,
   output logic             counter2_output_pin,
   output logic             int_out_pin,
   output logic             host_irq
);

   // Section index: group*4 + {0 A, 1 B, 2 C low, 3 C high}
   function automatic logic [47:0] expand(input logic [7:0] s);
      expand = {{NIB_W{s[7]}}, {NIB_W{s[6]}}, {PORT_W{s[5]}}, {PORT_W{s[4]}},
                {NIB_W{s[3]}}, {NIB_W{s[2]}}, {PORT_W{s[1]}}, {PORT_W{s[0]}}};
   endfunction

   // Channel source pick from the two mode bits
   function automatic logic pick(input logic [1:0] m, input logic pc0,
                                 input logic cnt, input logic pc4);
      case (dpp_src_t'(m))
         DPP_SRC_PC0: pick = pc0;
         DPP_SRC_CNT: pick = cnt;
         DPP_SRC_PC4: pick = pc4;
         default:     pick = 1'b0;
      endcase
   endfunction

   logic [7:0]  dir_ff;
   logic [47:0] out_ff;
   logic [47:0] oe_ff;
   logic        run_ff;
   logic [7:0]  shadow_dir_ff;
   logic [47:0] shadow_out_ff;
   logic        retain_valid_ff;
   logic [7:0]  irq_ctl_ff;
   logic [1:0]  flag_ff;
   logic [5:0]  src_prev_ff;
   logic        int_out_ff;
   logic        host_irq_ff;
   logic [7:0]  rdata_ff;
   logic [2:0]  clk_prev_ff;
   logic [7:0]  nxt_dir;
   logic [47:0] nxt_out;
   logic [1:0]  nxt_flag;
   logic [NCNT-1:0] cnt_out;

   // Strap-forced sections, same order as dir_ff
   wire [7:0] strap_out = {group1_portc_high_direction_strap,
                           group1_portc_low_direction_strap,
                           group1_portb_direction_strap,
                           group1_porta_direction_strap,
                           group0_portc_high_direction_strap,
                           group0_portc_low_direction_strap,
                           group0_portb_direction_strap,
                           group0_porta_direction_strap};

   // Address decode
   wire       hit_ctl0  = bus_addr == OFF_G0_CTL;
   wire       hit_ctl1  = bus_addr == OFF_G1_CTL;
   wire       hit_irq   = bus_addr == OFF_IRQ;
   wire       hit_cctl  = bus_addr == OFF_CNT_CTL;
   wire       hit_g0    = (bus_addr == OFF_G0_PA) || (bus_addr == OFF_G0_PB) ||
                          (bus_addr == OFF_G0_PC);
   wire       hit_g1    = (bus_addr == OFF_G1_PA) || (bus_addr == OFF_G1_PB) ||
                          (bus_addr == OFF_G1_PC);
   wire       hit_port  = hit_g0 || hit_g1;
   wire [2:0] byte_idx  = hit_g1 ? 3'(bus_addr[1:0]) + G1_BYTE_BASE : 3'(bus_addr[1:0]);
   wire       wr_ok     = bus_wr && run_ff;
   wire       restore   = !run_ff && state_retention_strap && retain_valid_ff;

   // Mode-0 control word: a set bit means input
   wire [3:0] cw_out = {~bus_wdata[CW_PCH], ~bus_wdata[CW_PCL],
                        ~bus_wdata[CW_PB], ~bus_wdata[CW_PA]};

   // Input pins read live, outputs read their latch
   wire [47:0] view = (out_ff & oe_ff) | (port_in & ~oe_ff);

   // Direction and latch next values
   always_comb begin
      nxt_dir = dir_ff;
      nxt_out = out_ff;
      if (restore) begin
         nxt_dir = shadow_dir_ff;
         nxt_out = shadow_out_ff;
      end else if (wr_ok && hit_ctl0) begin
         nxt_dir[3:0] = cw_out;
      end else if (wr_ok && hit_ctl1) begin
         nxt_dir[7:4] = cw_out;
      end else if (wr_ok && hit_port) begin
         nxt_out[byte_idx*PORT_W +: PORT_W] = bus_wdata;
      end
   end

   // Working port state; reset gives inputs, latches zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dir_ff <= REG_RST;
         out_ff <= OUT_RST;
         oe_ff  <= OUT_RST;
         run_ff <= 1'b0;
      end else begin
         dir_ff <= nxt_dir;
         out_ff <= nxt_out;
         // Strap wins over software direction
         oe_ff  <= expand(nxt_dir | strap_out);
         run_ff <= 1'b1;
      end
   end

   // Pins follow latch and direction with no gating
   assign port_out = out_ff;
   assign port_oe  = oe_ff;

   // Retained copy lives only on the supply reset; frozen while rst_b holds run_ff low
   always_ff @(posedge clk or negedge por_b) begin
      if (!por_b) begin
         shadow_dir_ff   <= REG_RST;
         shadow_out_ff   <= OUT_RST;
         retain_valid_ff <= 1'b0;
      end else if (run_ff) begin
         shadow_dir_ff   <= dir_ff;
         shadow_out_ff   <= out_ff;
         retain_valid_ff <= 1'b1;
      end
   end

   // Interrupt sources and edge detect
   wire [1:0] src_lvl;
   assign src_lvl[0] = pick(irq_ctl_ff[IRQ_M0_LO +: 2], view[G0_PC0],
                            cnt_out[1], view[G0_PC4]);
   assign src_lvl[1] = pick(irq_ctl_ff[IRQ_M1_LO +: 2], view[G1_PC0],
                            cnt_out[2], view[G1_PC4]);
   wire [1:0] edge_sel = {irq_ctl_ff[IRQ_E1], irq_ctl_ff[IRQ_E0]};
   // History of every candidate, selected or not, so switching source is no edge
   wire [5:0] src_raw  = {view[G1_PC4], cnt_out[2], view[G1_PC0],
                          view[G0_PC4], cnt_out[1], view[G0_PC0]};
   wire [1:0] src_old;
   assign src_old[0] = pick(irq_ctl_ff[IRQ_M0_LO +: 2], src_prev_ff[0],
                            src_prev_ff[1], src_prev_ff[2]);
   assign src_old[1] = pick(irq_ctl_ff[IRQ_M1_LO +: 2], src_prev_ff[3],
                            src_prev_ff[4], src_prev_ff[5]);
   wire [1:0] rise     = src_lvl & ~src_old;
   wire [1:0] fall     = ~src_lvl & src_old;
   wire [1:0] fire     = (edge_sel & rise) | (~edge_sel & fall);
   wire       irq_wr   = bus_wr && hit_irq;
   wire [1:0] clr      = irq_wr ? {bus_wdata[IRQ_F1], bus_wdata[IRQ_F0]} : 2'b00;

   // New edge beats a clear in the same cycle
   assign nxt_flag = fire | (flag_ff & ~clr);

   // Interrupt control and flags
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_ctl_ff  <= REG_RST;
         flag_ff     <= 2'b00;
         src_prev_ff <= 6'h00;
         int_out_ff  <= 1'b0;
         host_irq_ff <= 1'b0;
      end else begin
         if (irq_wr) begin
            irq_ctl_ff <= bus_wdata;
         end
         flag_ff     <= nxt_flag;
         src_prev_ff <= src_raw;
         int_out_ff  <= |nxt_flag;
         host_irq_ff <= |nxt_flag;
      end
   end

   assign int_out_pin = int_out_ff;
   assign host_irq    = host_irq_ff;

   // Read data; flags replace the stored flag positions
   wire [7:0] irq_view = {flag_ff[1], irq_ctl_ff[IRQ_E1:IRQ_M1_LO],
                          flag_ff[0], irq_ctl_ff[IRQ_E0:IRQ_M0_LO]};
   wire [7:0] rd_mux   = hit_port ? view[byte_idx*PORT_W +: PORT_W] :
                         hit_irq  ? irq_view : REG_RST;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_ff <= REG_RST;
      end else if (bus_rd) begin
         rdata_ff <= rd_mux;
      end
   end

   assign bus_rdata = rdata_ff;

   // Clock source routing; strap high picks the internal source
   wire [2:0] clk_sel = {counter2_clock_select_strap, counter1_clock_select_strap,
                         counter0_clock_select_strap};
   wire [2:0] clk_int = {int_clock_10m, cnt_out[0], int_clock_10m};
   wire [2:0] clk_ext = {counter2_ext_clock_pin, counter1_ext_clock_pin,
                         counter0_ext_clock_pin};
   wire [2:0] clk_lvl = (clk_sel & clk_int) | (~clk_sel & clk_ext);
   wire [2:0] tick    = clk_lvl & ~clk_prev_ff;
   // Open gate pins are pulled high outside, so gating defaults on
   wire [2:0] gate    = {counter2_gate_pin, counter1_gate_pin, counter0_gate_pin};
   wire [1:0] cnt_sel = bus_wdata[CTL_SC_LO +: 2];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clk_prev_ff <= 3'h0;
      end else begin
         clk_prev_ff <= clk_lvl;
      end
   end

   // Three identical counters
   genvar i;
   generate
      for (i = 0; i < NCNT; i++) begin : g_cnt
         dpp_counter u_cnt (
            .clk     (clk),
            .rst_b   (rst_b),
            .tick    (tick[i]),
            .gate    (gate[i]),
            .load_wr (bus_wr && (bus_addr == OFF_CNT0 + 6'(i))),
            .mode_wr (bus_wr && hit_cctl && (cnt_sel == 2'(i))),
            .wdata   (bus_wdata),
            .cnt_out (cnt_out[i])
         );
      end
   endgenerate

   assign counter0_output_pin = cnt_out[0];
   assign counter1_output_pin = cnt_out[1];
   assign counter2_output_pin = cnt_out[2];

endmodule

// [verification/dpp_host.sv]
// Purpose: Host processor model on the register port
// Assumes: One access at a time, strobes one cycle wide
// Notes:   Released lines carry inverted values, never the old ones
`timescale 1ns/10ps
module dpp_host (
   input  wire logic       clk,
   input  wire logic [7:0] bus_rdata,
   output logic [5:0]      bus_addr,
   output logic            bus_wr,
   output logic            bus_rd,
   output logic [7:0]      bus_wdata
);
   int idle = 0; // Extra idle cycles for a slow host
   // Quiet bus at time zero
   initial begin
      bus_addr  = 6'h00;
      bus_wdata = 8'h00;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
   end
   // Launch off the falling edge, release after the taking edge
   task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
      repeat (idle + 1) @(negedge clk);
      bus_addr  = a;
      bus_wdata = d;
      bus_wr    = w;
      bus_rd    = !w;
      @(negedge clk);
      q         = bus_rdata;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      bus_addr  = ~a;
      bus_wdata = ~d;
   endtask
endmodule

// [verification/dpp_top_props.sv]
// Purpose: Concurrent checks on the parallel port block, ports and interrupt pins
// Assumes: Direction straps move only while reset is held
// Notes:   Bound into dpp_top below the module
`timescale 1ns/10ps
module dpp_top_props
   import dpp_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [5:0]  bus_addr,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic [7:0]  bus_wdata,
   input wire logic [7:0]  bus_rdata,
   input wire logic [47:0] port_out,
   input wire logic [47:0] port_oe,
   input wire logic        group0_porta_direction_strap,
   input wire logic        group1_porta_direction_strap,
   input wire logic        int_out_pin,
   input wire logic        host_irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Decoded strobes used by several checks
   wire ctl0_wr = bus_wr && bus_addr == OFF_G0_CTL;
   wire irq_wr  = bus_wr && bus_addr == OFF_IRQ;
   wire irq_rd  = bus_rd && bus_addr == OFF_IRQ;

   // Reset itself must not be masked here, so the default is overridden
   chk_reset_quiet: assert property (disable iff (1'b0)
      !rst_b && $past(!rst_b) |-> port_oe == 48'h0 && port_out == 48'h0 && !int_out_pin)
      else $error("outputs active during reset");
   chk_ctl_sets_dir: assert property (
      ctl0_wr && $past(rst_b) && !group0_porta_direction_strap
      |=> port_oe[7:0] == {8{!$past(bus_wdata[CW_PA])}})
      else $error("control word did not set port direction");
   chk_strap_forced: assert property (
      $past(rst_b) && group1_porta_direction_strap |-> port_oe[31:24] == 8'hFF)
      else $error("strapped port not driving");
   chk_latch_write: assert property (
      bus_wr && bus_addr == OFF_G0_PB && $past(rst_b)
      |=> port_out[15:8] == $past(bus_wdata))
      else $error("latch write not seen on pins");
   chk_readback_out: assert property (
      bus_rd && bus_addr == OFF_G0_PB && port_oe[15:8] == 8'hFF
      |=> bus_rdata == $past(port_out[15:8]))
      else $error("output readback wrong");
   chk_oe_only_ctl: assert property (
      $past(rst_b) && $past(rst_b, 2) && !$past(bus_wr) |-> $stable(port_oe))
      else $error("direction changed without a write");
   chk_irq_pins_same: assert property (int_out_pin == host_irq)
      else $error("interrupt pins disagree");
   chk_flag_holds: assert property (
      int_out_pin && !irq_wr |=> int_out_pin)
      else $error("pending interrupt dropped without clear");
   chk_flag_reads: assert property (
      irq_rd |=> (bus_rdata[IRQ_F0] || bus_rdata[IRQ_F1]) == $past(int_out_pin))
      else $error("flags disagree with interrupt pin");
   chk_rd_ctl_zero: assert property (
      bus_rd && bus_addr == OFF_G1_CTL |=> bus_rdata == 8'h00)
      else $error("write-only control read nonzero");
   // Main scenarios reached
   cov_irq_raise: cover property ($rose(int_out_pin));
   cov_ctl_write: cover property (ctl0_wr);
   cov_flag_read: cover property (irq_rd && int_out_pin);
endmodule

bind dpp_top dpp_top_props u_dpp_top_props (
   .clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .port_out(port_out), .port_oe(port_oe),
   .group0_porta_direction_strap(group0_porta_direction_strap),
   .group1_porta_direction_strap(group1_porta_direction_strap),
   .int_out_pin(int_out_pin), .host_irq(host_irq));

// [verification/dpp_top_tb.sv]
// Purpose: Self-checking bench for the dual parallel port block
// Assumes: Pull-ups on every pin outside the block
// Notes:   Group 1 port A is strapped to output throughout
`timescale 1ns/10ps
module dpp_top_tb
   import dpp_pkg::*;
;
   logic        clk, rst_b, por_b, ret, clk10, bus_wr, bus_rd, int_out_pin, host_irq;
   logic [7:0]  strap, bus_wdata, bus_rdata;
   logic [5:0]  bus_addr;
   logic [2:0]  csel, cext, gate, cout;
   logic [47:0] ext, port_out, port_oe;
   int          bad_count, checks_done;
   // Pin level: driven value, else the field side (pulled high)
   wire [47:0] pins = (port_oe & port_out) | (~port_oe & ext);

   dpp_top u_dpp_top (.clk(clk), .rst_b(rst_b), .por_b(por_b), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .port_in(pins), .port_out(port_out), .port_oe(port_oe), .state_retention_strap(ret),
      .group0_porta_direction_strap(strap[0]), .group0_portb_direction_strap(strap[1]),
      .group0_portc_low_direction_strap(strap[2]), .group0_portc_high_direction_strap(strap[3]),
      .group1_porta_direction_strap(strap[4]), .group1_portb_direction_strap(strap[5]),
      .group1_portc_low_direction_strap(strap[6]), .group1_portc_high_direction_strap(strap[7]),
      .counter0_clock_select_strap(csel[0]), .counter1_clock_select_strap(csel[1]),
      .counter2_clock_select_strap(csel[2]), .int_clock_10m(clk10),
      .counter0_ext_clock_pin(cext[0]), .counter1_ext_clock_pin(cext[1]),
      .counter2_ext_clock_pin(cext[2]), .counter0_gate_pin(gate[0]),
      .counter1_gate_pin(gate[1]), .counter2_gate_pin(gate[2]),
      .counter0_output_pin(cout[0]), .counter1_output_pin(cout[1]),
      .counter2_output_pin(cout[2]), .int_out_pin(int_out_pin), .host_irq(host_irq));
   dpp_host u_dpp_host (.clk(clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata));

   // 25 MHz system clock and free-running 10 MHz source
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      clk10 = 1'b0;
      forever #50 clk10 = ~clk10;
   end

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_dpp_host.xfer(1'b1, a, d, q);
   endtask
   task automatic rdchk(input logic [5:0] a, input logic [7:0] e, input string m);
      logic [7:0] q;
      u_dpp_host.xfer(1'b0, a, 8'h00, q);
      chk({40'h0, q}, {40'h0, e}, m);
   endtask
   // Hot reset, or supply loss as well when pwr is set
   task automatic do_reset(input logic pwr);
      @(negedge clk);
      rst_b = 1'b0;
      por_b = !pwr;
      cyc(10);
      por_b = 1'b1;
      rst_b = 1'b1;
      cyc(2);
   endtask
   task automatic pin(input int b, input logic v);
      @(negedge clk);
      ext[b] = v;
      cyc(4);
   endtask

   task automatic t_defaults();
      do_reset(1'b1);
      chk(port_oe, 48'h0000_FF00_0000, "oe after power-up");
      chk(port_out, 48'h0, "latches after power-up");
      rdchk(OFF_G0_PB, 8'hFF, "input pulled high");
      rdchk(OFF_IRQ, 8'h00, "interrupt reg reset");
      $display("defaults done");
   endtask
   task automatic t_dir();
      wr(OFF_G0_PB, 8'hA5);
      wr(OFF_G0_CTL, 8'h00);
      chk(port_oe[23:0], 24'hFFFFFF, "group 0 outputs");
      chk(port_out[15:8], 8'hA5, "latch on pins");
      rdchk(OFF_G0_PB, 8'hA5, "output readback");
      wr(OFF_G0_CTL, 8'h19);
      wr(OFF_G1_CTL, 8'h1B);
      chk(port_oe[47:24], 24'h0000FF, "strap overrides word");
      wr(OFF_G1_CTL, 8'h01);
      chk(port_oe, 48'hF0FFFF_00FF00, "mixed directions");
      rdchk(OFF_G1_CTL, 8'h00, "control write-only");
      rdchk(6'h3F, 8'h00, "unmapped read");
      $display("direction done");
   endtask
   task automatic t_retain();
      wr(OFF_G1_PA, 8'h3C);
      wr(OFF_G0_PB, 8'h5A);
      ret = 1'b1;
      do_reset(1'b0);
      chk(port_oe, 48'hF0FFFF_00FF00, "hot reset directions");
      chk(port_out, 48'h0000_3C00_5A00, "hot reset latches");
      do_reset(1'b1);
      chk(port_oe, 48'h0000_FF00_0000, "supply loss directions");
      chk(port_out, 48'h0, "supply loss latches");
      ret = 1'b0;
      wr(OFF_G0_CTL, 8'h00);
      do_reset(1'b0);
      chk(port_oe, 48'h0000_FF00_0000, "no retention");
      $display("retention done");
   endtask
   task automatic t_irq();
      wr(OFF_IRQ, 8'h51);
      pin(G0_PC0, 1'b0);
      chk(int_out_pin, 1'b1, "falling edge raises");
      pin(G1_PC0, 1'b0);
      rdchk(OFF_IRQ, 8'h59, "only channel 0 pending");
      pin(G1_PC0, 1'b1);
      rdchk(OFF_IRQ, 8'hD9, "channel 1 pending");
      wr(OFF_IRQ, 8'hD9);
      pin(G0_PC0, 1'b1);
      chk(int_out_pin, 1'b0, "cleared, wrong edge");
      wr(OFF_IRQ, 8'h07);
      pin(G0_PC4, 1'b0);
      pin(G0_PC4, 1'b1);
      pin(G1_PC0, 1'b0);
      rdchk(OFF_IRQ, 8'h0F, "bit 4 source, channel off");
      wr(OFF_IRQ, 8'h8F);
      chk(int_out_pin, 1'b0, "cleared");
      $display("interrupt done");
   endtask
   task automatic t_cnt();
      int n;
      u_dpp_host.idle = 2;
      wr(OFF_IRQ, 8'h8E);
      wr(OFF_CNT_CTL, 8'h40);
      wr(OFF_CNT1, 8'h02);
      wr(OFF_CNT1, 8'h00);
      chk(cout[1], 1'b0, "counting, output low");
      n = 0;
      while (cout[1] !== 1'b1 && n < 5) begin
         chk(int_out_pin, 1'b0, "no early interrupt");
         @(negedge clk);
         cext[1] = 1'b1;
         cyc(3);
         cext[1] = 1'b0;
         cyc(3);
         n++;
      end
      chk(n > 1, 1'b1, "count of two needs two edges");
      chk(cout[1], 1'b1, "terminal count");
      cyc(2);
      chk(int_out_pin, 1'b1, "counter interrupt");
      $display("counter done");
   endtask

   // Internal clocks: counter 0 rate output cascades into counter 1
   task automatic t_casc();
      csel = 3'b111;
      gate[2] = 1'b0;
      wr(OFF_CNT_CTL, 8'h04);
      wr(OFF_CNT0, 8'h02);
      wr(OFF_CNT0, 8'h00);
      chk(cout[0], 1'b1, "rate output starts high");
      wr(OFF_CNT_CTL, 8'h40);
      wr(OFF_CNT1, 8'h02);
      wr(OFF_CNT1, 8'h00);
      chk(cout[1], 1'b0, "cascade armed");
      wr(OFF_CNT_CTL, 8'h80);
      wr(OFF_CNT2, 8'h02);
      wr(OFF_CNT2, 8'h00);
      cyc(30);
      chk(cout[1], 1'b1, "cascade terminal");
      chk(cout[2], 1'b0, "gate low holds count");
      gate[2] = 1'b1;
      cyc(10);
      chk(cout[2], 1'b1, "internal timer ends");
      $display("cascade done");
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Main sequence, all inputs set at time zero
   initial begin
      bad_count = 0;
      checks_done = 0;
      rst_b = 1'b0;
      por_b = 1'b0;
      ret = 1'b0;
      strap = 8'h10;
      csel = 3'b000;
      cext = 3'b000;
      gate = 3'b111;
      ext = 48'hFFFF_FFFF_FFFF;
      t_defaults();
      t_dir();
      t_retain();
      t_irq();
      t_cnt();
      t_casc();
      print_verdict();
   end
   // Watchdog, about twenty times the expected run
   initial begin
      #200000;
      bad_count++;
      print_verdict();
   end
endmodule
